/* File: hw/gtw_pkg.sv */
// package: constants and carrier types of the two-wire register port
package gtw_pkg;
   localparam logic [6:0] DEV_ADDR = 7'h36;
   localparam logic [8:0] WR_LAST = 9'h04f;
   localparam logic [8:0] PTR_MAX = 9'h0ff;
   localparam logic [8:0] PTR_PAST = 9'h100;
   localparam logic [8:0] PTR_ONE = 9'h001;
   localparam logic [7:0] FILL_BYTE = 8'hff;
   localparam logic [3:0] BIT_LAST = 4'h7;
   localparam logic [3:0] BIT_ACK = 4'h8;
   localparam logic [3:0] BIT_ONE = 4'h1;
   localparam logic [2:0] MSB_IDX = 3'h7;
   localparam logic RW_READ = 1'b1;
   localparam logic ACK_LOW = 1'b0;

   typedef enum logic [2:0] {
      GTW_IDLE = 3'b000,
      GTW_ADDR = 3'b001,
      GTW_PTR = 3'b010,
      GTW_WDATA = 3'b011,
      GTW_RDATA = 3'b100,
      GTW_IGNORE = 3'b101
   } gtw_state_t;

   typedef struct packed {
      logic scl;
      logic sda;
   } gtw_pins_t;

   typedef struct packed {
      logic [6:0] idx;
      logic [15:0] data;
   } gtw_wr_t;

   // clock-domain state
   typedef struct packed {
      gtw_pins_t pin_m;
      gtw_pins_t pin_s;
      gtw_pins_t pin_p;
      logic [1:0] tg_m;
      logic [1:0] tg_s;
      logic [1:0] tg_p;
      gtw_state_t st;
      logic [8:0] ptr;
      logic [7:0] rxb;
      logic [7:0] hi;
      logic hi_ok;
      logic [15:0] shadow;
      logic shadow_ok;
      logic [7:0] tx;
      logic tx_on;
      logic ack_en;
      logic pend;
      logic load;
      logic lrst_n;
      logic wr_stb;
      gtw_wr_t wr;
   } gtw_core_t;

   // link-domain state, cleared by start, stop and idle
   typedef struct packed {
      logic [3:0] bitcnt;
      logic [6:0] sh;
   } gtw_lctl_t;

   // link-domain events, kept across frames
   typedef struct packed {
      logic rx_tgl;
      logic ack_tgl;
      logic [7:0] rx_byte;
      logic mack;
   } gtw_levt_t;
endpackage

/* File: hw/gtw_port.sv */
// two-wire slave port with 16-bit register access toward the core
`timescale 1ns/10ps
// Operation
// [R1] receiver acks by holding sda low bit nine
// [R2] nack: sda released through ninth clock
// [R3] master retries after failed acknowledge
// [R4] bytes are eight bits msb first
// [R5] high byte at even address, low next
// [R6] idle bus: watch start then own address
// [R7] fixed address, 6c write 6d read
// [R8] ack right after matching direction bit
// [R9] direction 0 write, 1 read
// [R10] any scl rate to 400 khz
// [R11] first write byte sets the pointer
// [R12] pointer advances after each written byte
// [R13] writes past 4f are dropped
// [R14] register updates only with both bytes
// [R15] writes to read-only registers dropped
// [R16] cut or unacked bytes never stored
// [R17] master ends write after final ack
// [R18] read: pointer write, restart, device drives
// [R19] sender owns sda except ack cycles
// [R20] read high byte first, pointer advances
// [R21] master reads both bytes in one frame
// [R22] beyond ff read returns ff
// [R23] master nack ends read, device releases
// [R24] start and stop only while scl high
// [R25] sda input, open-drain low drive only
// [R26] high byte read captures whole register
// [R27] high byte buffered until low byte acked
module gtw_port
   import gtw_pkg::*;
(
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   output logic [6:0] idx_o,
   input wire logic [15:0] rd_data_i,
   input wire logic wr_allow_i,
   output logic wr_stb_o,
   output logic [6:0] wr_idx_o,
   output logic [15:0] wr_data_o
);
   gtw_core_t c_q;
   gtw_core_t c_d;
   gtw_lctl_t l_q;
   gtw_lctl_t l_d;
   gtw_levt_t e_q;
   gtw_levt_t e_d;
   logic oe_q;
   logic oe_d;
   logic lnk_rst_n;
   logic start_ev;
   logic stop_ev;
   logic rx_ev;
   logic ack_ev;

   // pointer stops one past the top so every later read stays filled
   function automatic logic [8:0] ptr_inc(input logic [8:0] p);
      if (p[8]) begin
         ptr_inc = PTR_PAST;
      end else begin
         ptr_inc = p + PTR_ONE;
      end
   endfunction

   // link side: no speed setting, scl clocks the shifter directly [R10]
   assign lnk_rst_n = rstn_i & c_q.lrst_n;

   always_comb begin
      l_d = l_q;
      e_d = e_q;
      if (l_q.bitcnt == BIT_ACK) begin
         // ninth clock: acknowledge from whichever side received
         e_d.mack = sda_i;
         e_d.ack_tgl = ~e_q.ack_tgl;
         l_d.bitcnt = '0;
      end else begin
         l_d.sh = {l_q.sh[5:0], sda_i}; // [R4]
         l_d.bitcnt = l_q.bitcnt + BIT_ONE;
         if (l_q.bitcnt == BIT_LAST) begin
            e_d.rx_byte = {l_q.sh, sda_i}; // [R4]
            e_d.rx_tgl = ~e_q.rx_tgl;
         end
      end
   end

   always_ff @(posedge scl_i or negedge lnk_rst_n) begin
      if (!lnk_rst_n) begin
         l_q <= '0;
      end else begin
         l_q <= l_d;
      end
   end

   always_ff @(posedge scl_i or negedge rstn_i) begin
      if (!rstn_i) begin
         e_q <= '0;
      end else begin
         e_q <= e_d;
      end
   end

   // sda moves only on falling scl, so it never mimics start or stop
   always_comb begin
      oe_d = 1'b0;
      if (l_q.bitcnt == BIT_ACK) begin
         oe_d = c_q.ack_en; // [R1] [R2] [R8]
      end else if (c_q.tx_on) begin
         oe_d = ~c_q.tx[MSB_IDX - l_q.bitcnt[2:0]]; // [R19] [R4]
      end
   end

   // tx, tx_on and ack_en are settled long before the falling edge:
   // the core side answers within tens of ns of each link event
   always_ff @(negedge scl_i or negedge lnk_rst_n) begin
      if (!lnk_rst_n) begin
         oe_q <= 1'b0;
      end else begin
         oe_q <= oe_d; // [R24]
      end
   end

   assign sda_o = 1'b0; // [R25]
   assign sda_oe_o = oe_q; // [R25]

   // core side
   assign start_ev = c_q.pin_s.scl & c_q.pin_p.scl & c_q.pin_p.sda & ~c_q.pin_s.sda; // [R24]
   assign stop_ev = c_q.pin_s.scl & c_q.pin_p.scl & ~c_q.pin_p.sda & c_q.pin_s.sda; // [R24]
   assign rx_ev = c_q.tg_s[0] ^ c_q.tg_p[0];
   assign ack_ev = c_q.tg_s[1] ^ c_q.tg_p[1];

   always_comb begin
      c_d = c_q;
      c_d.pin_m = '{scl: scl_i, sda: sda_i};
      c_d.pin_s = c_q.pin_m;
      c_d.pin_p = c_q.pin_s;
      c_d.tg_m = {e_q.ack_tgl, e_q.rx_tgl};
      c_d.tg_s = c_q.tg_m;
      c_d.tg_p = c_q.tg_s;
      c_d.wr_stb = 1'b0;
      c_d.load = 1'b0;
      // link held cleared while idle and for one cycle on start or stop
      c_d.lrst_n = (c_q.st != GTW_IDLE) & ~start_ev & ~stop_ev; // [R6]
      if (c_q.load) begin
         if (c_q.ptr[8]) begin
            c_d.tx = FILL_BYTE; // [R22]
         end else if (!c_q.ptr[0]) begin
            c_d.shadow = rd_data_i; // [R26]
            c_d.shadow_ok = 1'b1;
            c_d.tx = rd_data_i[15:8]; // [R5] [R20]
         end else if (c_q.shadow_ok) begin
            c_d.tx = c_q.shadow[7:0]; // [R26]
         end else begin
            c_d.tx = rd_data_i[7:0];
         end
      end
      if (start_ev) begin
         // repeated start keeps the pointer for the read portion [R18]
         c_d.st = GTW_ADDR; // [R6]
         c_d.tx_on = 1'b0;
         c_d.ack_en = 1'b0;
         c_d.pend = 1'b0;
         c_d.hi_ok = 1'b0; // [R14]
      end else if (stop_ev) begin
         c_d.st = GTW_IDLE;
         c_d.tx_on = 1'b0;
         c_d.ack_en = 1'b0;
         c_d.pend = 1'b0;
         c_d.hi_ok = 1'b0; // [R16]
      end else if (rx_ev) begin
         c_d.rxb = e_q.rx_byte;
         c_d.pend = 1'b0;
         case (c_q.st)
            GTW_ADDR: begin
               if (e_q.rx_byte[7:1] == DEV_ADDR) begin // [R7]
                  c_d.ack_en = 1'b1; // [R8]
                  if (e_q.rx_byte[0] == RW_READ) begin // [R9]
                     c_d.st = GTW_RDATA;
                     c_d.tx_on = 1'b1; // [R18]
                     c_d.shadow_ok = 1'b0;
                     c_d.load = 1'b1;
                  end else begin
                     c_d.st = GTW_PTR;
                  end
               end else begin
                  c_d.ack_en = 1'b0; // [R2]
                  c_d.st = GTW_IGNORE;
               end
            end
            GTW_PTR: begin
               c_d.ptr = {1'b0, e_q.rx_byte}; // [R11]
               c_d.ack_en = 1'b1;
               c_d.hi_ok = 1'b0;
               c_d.st = GTW_WDATA;
            end
            GTW_WDATA: begin
               c_d.ack_en = 1'b1; // [R1]
               c_d.pend = 1'b1;
            end
            GTW_RDATA: begin
               c_d.ack_en = 1'b0; // [R19]
               c_d.pend = 1'b1;
            end
            default: begin
               c_d.ack_en = 1'b0;
            end
         endcase
      end else if (ack_ev && c_q.pend) begin
         c_d.pend = 1'b0;
         if (c_q.st == GTW_WDATA) begin
            // stored only once the ninth clock carried our acknowledge [R16]
            if (!c_q.ptr[0]) begin
               c_d.hi = c_q.rxb; // [R27] [R5]
               c_d.hi_ok = 1'b1;
            end else begin
               c_d.hi_ok = 1'b0;
               if (c_q.hi_ok && c_q.ptr <= WR_LAST && wr_allow_i) begin // [R13] [R14] [R15]
                  c_d.wr_stb = 1'b1; // [R27]
                  c_d.wr = '{idx: c_q.ptr[7:1], data: {c_q.hi, c_q.rxb}};
               end
            end
            c_d.ptr = ptr_inc(c_q.ptr); // [R12]
         end else if (c_q.st == GTW_RDATA) begin
            if (e_q.mack == ACK_LOW) begin
               c_d.ptr = ptr_inc(c_q.ptr); // [R20]
               c_d.load = 1'b1;
            end else begin
               // master nack: hand sda back, wait for stop or restart
               c_d.tx_on = 1'b0; // [R23]
               c_d.st = GTW_IGNORE;
            end
         end
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         c_q <= '0;
      end else begin
         c_q <= c_d;
      end
   end

   // read index follows the pointer; core answers combinationally
   assign idx_o = c_q.ptr[7:1];
   assign wr_stb_o = c_q.wr_stb;
   assign wr_idx_o = c_q.wr.idx;
   assign wr_data_o = c_q.wr.data;
endmodule

/* File: sim/gtw_chk.sv */
// pin-level checks on the two-wire register port
`timescale 1ns/10ps
module gtw_chk (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic scl_i,
   input wire logic sda_o,
   input wire logic sda_oe_o,
   input wire logic wr_stb_o,
   input wire logic [6:0] wr_idx_o,
   input wire logic [15:0] wr_data_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   chk_sda_zero: assert property (sda_o == 1'b0)
      else $error("sda data value not zero");
   chk_stb_single: assert property (wr_stb_o |=> !wr_stb_o [*8])
      else $error("write strobe too long");
   chk_wr_limit: assert property (wr_stb_o |-> wr_idx_o <= 7'h27)
      else $error("write beyond last writable index");
   chk_data_hold: assert property ($changed(wr_data_o) |-> wr_stb_o)
      else $error("write data moved without strobe");
   chk_idx_hold: assert property ($changed(wr_idx_o) |-> wr_stb_o)
      else $error("write index moved without strobe");
   chk_oe_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i)
      else $error("sda drive changed with scl high");
   chk_oe_high_hold: assert property ($rose(scl_i) |-> $stable(sda_oe_o) [*8])
      else $error("sda drive not held over scl high");
   chk_commit_ack: assert property (wr_stb_o |-> sda_oe_o && scl_i)
      else $error("commit outside acked ninth clock");
   cover property (wr_stb_o);
   cover property ($fell(sda_oe_o));
   cover property (wr_stb_o && wr_idx_o == 7'h27);
endmodule
bind gtw_port gtw_chk i_gtw_chk (.clk_i(clk_i), .rstn_i(rstn_i), .scl_i(scl_i),
   .sda_o(sda_o), .sda_oe_o(sda_oe_o), .wr_stb_o(wr_stb_o), .wr_idx_o(wr_idx_o),
   .wr_data_o(wr_data_o));

/* File: sim/gtw_master.sv */
// bus master model: drives scl, pulls sda low
`timescale 1ns/10ps
module gtw_master (
   output logic scl_o,
   output logic sda_oe_o,
   input wire logic sda_i
);
   // scl rests high between frames
   initial begin
      scl_o = 1'b1;
      sda_oe_o = 1'b0;
   end
   // low 60 ns, high 100 ns: period 160 ns
   task automatic bit_io(input logic b, output logic r);
      #20 sda_oe_o = !b;
      #40 scl_o = 1'b1;
      #50 r = sda_i;
      #50 scl_o = 1'b0;
   endtask
   task automatic start;
      sda_oe_o = 1'b0;
      #20 scl_o = 1'b1;
      #50 sda_oe_o = 1'b1;
      #50 scl_o = 1'b0;
   endtask
   task automatic stop;
      #20 sda_oe_o = 1'b1;
      #40 scl_o = 1'b1;
      #50 sda_oe_o = 1'b0;
      #100;
   endtask
   task automatic xfer(input logic [7:0] w, input logic ak, output logic [7:0] r,
      output logic a);
      for (int i = 7; i >= 0; i--)
         bit_io(w[i], r[i]);
      bit_io(ak, a);
   endtask
endmodule

/* File: sim/gtw_port_tb.sv */
// self-checking bench of the two-wire register port
`timescale 1ns/10ps
`define CHK(a, b) cmp(16'(a), 16'(b))
module gtw_port_tb
   import gtw_pkg::*;
;
   logic clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic scl, m_oe, sda_oe_o, sda_o, wr_stb_o;
   logic [6:0] idx_o, wr_idx_o;
   logic [15:0] rd_data_i, wr_data_o;
   logic [15:0] mem [128];
   logic [15:0] exp [128];
   int seed = 33;
   int failures = 0;
   int tests_run = 0;
   int cyc = 0;
   wire sda = !(m_oe | sda_oe_o);
   // index 2 stands for a read-only register
   wire logic wr_allow_i = idx_o != 7'h02;
   assign rd_data_i = mem[idx_o];
   always #5 clk_i = !clk_i;
   gtw_master i_gtw_master (.scl_o(scl), .sda_oe_o(m_oe), .sda_i(sda));
   gtw_port i_gtw_port (.clk_i(clk_i), .rstn_i(rstn_i), .scl_i(scl), .sda_i(sda),
      .sda_o(sda_o), .sda_oe_o(sda_oe_o), .idx_o(idx_o), .rd_data_i(rd_data_i),
      .wr_allow_i(wr_allow_i), .wr_stb_o(wr_stb_o), .wr_idx_o(wr_idx_o),
      .wr_data_o(wr_data_o));
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (wr_stb_o === 1'b1)
         mem[wr_idx_o] <= wr_data_o;
      if (cyc == 20000) begin
         failures++;
         final_report;
      end
   end
   task automatic cmp(input logic [15:0] got, input logic [15:0] want);
      tests_run++;
      if (got !== want) begin
         failures++;
         $display("wrong value at %0t: %h, expected %h", $time, got, want);
      end
   endtask
   function automatic logic [7:0] want(input logic [8:0] p);
      if (p > PTR_MAX)
         return FILL_BYTE;
      return p[0] ? exp[p[7:1]][7:0] : exp[p[7:1]][15:8];
   endfunction
   task automatic wr(input logic [8:0] p, input int n, input bit cut);
      logic [7:0] b, h, r;
      logic a;
      i_gtw_master.start;
      i_gtw_master.xfer(8'h6c, 1'b1, r, a);
      `CHK(a, 1'b0);
      i_gtw_master.xfer(p[7:0], 1'b1, r, a);
      `CHK(a, 1'b0);
      for (int i = 0; i < n; i++) begin
         b = 8'($random(seed));
         i_gtw_master.xfer(b, 1'b1, r, a);
         `CHK(a, 1'b0);
         // lone low byte has no buffered high byte to pair with
         if (p[0] && i > 0 && p <= WR_LAST && p[7:1] != 7'h02)
            exp[p[7:1]] = {h, b};
         h = b;
         p++;
      end
      if (cut)
         repeat (4) i_gtw_master.bit_io(1'b0, r[0]);
      i_gtw_master.stop;
   endtask
   task automatic rd(input logic [8:0] p, input int n);
      logic [7:0] r;
      logic a;
      i_gtw_master.start;
      i_gtw_master.xfer(8'h6c, 1'b1, r, a);
      i_gtw_master.xfer(p[7:0], 1'b1, r, a);
      i_gtw_master.start;
      i_gtw_master.xfer(8'h6d, 1'b1, r, a);
      `CHK(a, 1'b0);
      for (int i = 0; i < n; i++) begin
         i_gtw_master.xfer(8'hff, i == n - 1, r, a);
         `CHK(r, want(p));
         p++;
      end
      i_gtw_master.stop;
      `CHK(sda_oe_o, 1'b0);
   endtask
   task final_report;
      $display("checks %0d, failures %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial begin
      logic [7:0] r;
      logic a;
      for (int i = 0; i < 128; i++) begin
         mem[i] = 16'($random(seed));
         exp[i] = mem[i];
      end
      repeat (12) @(posedge clk_i);
      rstn_i <= 1'b1;
      repeat (5) @(posedge clk_i);
      #3;
      i_gtw_master.start;
      i_gtw_master.xfer(8'h6a, 1'b1, r, a);
      `CHK(a, 1'b1);
      i_gtw_master.stop;
      wr(9'h002, 4, 1'b0);
      wr(9'h007, 3, 1'b0);
      wr(9'h00a, 1, 1'b1);
      wr(9'h04e, 4, 1'b0);
      rd(9'h002, 4);
      rd(9'h006, 6);
      rd(9'h04e, 4);
      rd(9'h0fe, 4);
      final_report;
   end
endmodule
